// *** sbr_pkg.sv ***
// constants, command and burst types shared by the sdram bank command model
package sbr_pkg;
   localparam int BANKS = 4;
   localparam int ROW_W = 12;
   localparam int COL_W = 9;
   localparam int DATA_W = 16;
   localparam int LANES = 2;
   localparam int STORE_COL_W = 4;
   localparam int STORE_IDX_W = 6;
   localparam int FIFO_DEPTH = 32;
   localparam int AUTO_CLOSE_BIT = 10;
   localparam int LEFT_W = 10;
   // burst length codes and word counts
   localparam logic [2:0] BL_CODE_1 = 3'h0;
   localparam logic [2:0] BL_CODE_2 = 3'h1;
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [LEFT_W-1:0] BL_WORDS_1 = 10'h001;
   localparam logic [LEFT_W-1:0] BL_WORDS_2 = 10'h002;
   localparam logic [LEFT_W-1:0] BL_WORDS_4 = 10'h004;
   localparam logic [LEFT_W-1:0] BL_WORDS_8 = 10'h008;
   localparam logic [LEFT_W-1:0] BL_WORDS_PAGE = 10'h200;
   // read latency code for three clocks; any other value means two
   localparam logic [1:0] READ_LATENCY_3 = 2'h3;
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int WRITE_RECOVERY_NS = 15;
   localparam int WR_RECOVERY_RAW = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] WR_RECOVERY_CYCLES = 4'(WR_RECOVERY_RAW < 1 ? 1 : WR_RECOVERY_RAW);
   // reset values
   localparam logic [BANKS-1:0] ACTIVE_RESET = 4'h0;
   localparam logic [ROW_W-1:0] ROW_RESET = 12'h000;
   localparam logic [COL_W-1:0] COL_RESET = 9'h000;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

   typedef enum logic [2:0] {
      CMD_NOP,
      CMD_OPEN_ROW,
      CMD_CLOSE_ONE,
      CMD_CLOSE_ALL,
      CMD_READ,
      CMD_WRITE
   } sbr_cmd_type;

   typedef enum logic [1:0] {
      BURST_IDLE,
      BURST_READ,
      BURST_WRITE,
      BURST_RECOVER
   } sbr_burst_type;

   typedef struct packed {
      logic [STORE_IDX_W-1:0] idx;
      logic [LANES-1:0] lane_en;
      logic [DATA_W-1:0] data;
   } sbr_wr_entry_type;
endpackage

// *** sbr_bank_rw.sv ***
// sdram bank command model: per-bank open/close, read and write bursts, write fifo
// Functional notes
// - commands and address taken on rising edge
// - open row activates bank, captures row
// - close-one returns selected bank to idle
// - close-all idles all four banks
// - read data after latency, one per edge
// - read latency is two or three clocks
// - full page bursts run on, wrap to zero
// - read mask acts two clocks after sampling
// - read burst cut by read, write, close
// - read auto-close closes bank after burst
// - full page skips automatic bank close
// - write word captured with command, then per edge
// - write burst cut by write, read, close
// - read interrupting write stops further writes
// - write auto-close closes after recovery
`timescale 1ns/1ps

module sbr_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 32
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store_reg [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;

   assign in_ready_o = (wr_ptr_reg[AW] == rd_ptr_reg[AW])
      || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
   assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
   assign out_data_o = store_reg[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (push) store_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
   end
endmodule

module sbr_bank_rw (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic bank_select_low_i,
   input wire logic bank_select_high_i,
   input wire logic [sbr_pkg::ROW_W-1:0] addr_i,
   input wire logic [sbr_pkg::LANES-1:0] dqm_i,
   input wire logic [sbr_pkg::DATA_W-1:0] dq_i,
   output logic [sbr_pkg::DATA_W-1:0] dq_o,
   output logic [sbr_pkg::LANES-1:0] dq_oe_n_o,
   input wire logic [1:0] read_latency_i,
   input wire logic [2:0] burst_len_code_i,
   output logic [sbr_pkg::BANKS-1:0] bank_active_o,
   output logic wr_fifo_ready_o
);
   // pins are synchronous to sys_clk_i by contract, so no synchroniser is used
   sbr_pkg::sbr_cmd_type cmd;
   sbr_pkg::sbr_burst_type state_reg, state_next;
   logic [sbr_pkg::BANKS-1:0] active_reg;
   logic [sbr_pkg::ROW_W-1:0] row_reg [sbr_pkg::BANKS];
   logic [1:0] bank_reg, bank_next;
   logic [sbr_pkg::COL_W-1:0] col_reg, col_next, wrap_reg, wrap_next;
   logic [sbr_pkg::LEFT_W-1:0] left_reg, left_next;
   logic full_reg, full_next, auto_reg, auto_next;
   logic [3:0] rec_reg, rec_next;
   logic [sbr_pkg::DATA_W-1:0] mem_reg [2**sbr_pkg::STORE_IDX_W];
   logic pa_valid_reg, pb_valid_reg;
   logic [sbr_pkg::DATA_W-1:0] pa_data_reg, pb_data_reg;
   logic [sbr_pkg::LANES-1:0] dqm_d1_reg, oe_n_reg;
   sbr_pkg::sbr_wr_entry_type push_entry, drain_entry;
   logic drain_valid;

   // command decode
   wire [1:0] bank = {bank_select_high_i, bank_select_low_i};
   wire auto_bit = addr_i[sbr_pkg::AUTO_CLOSE_BIT];
   wire [sbr_pkg::COL_W-1:0] cmd_col = addr_i[sbr_pkg::COL_W-1:0];
   wire [2:0] pins = {ras_n_i, cas_n_i, we_n_i};
   assign cmd = cs_n_i ? sbr_pkg::CMD_NOP
      : pins == 3'h3 ? sbr_pkg::CMD_OPEN_ROW
      : (pins == 3'h2 && !auto_bit) ? sbr_pkg::CMD_CLOSE_ONE
      : (pins == 3'h2) ? sbr_pkg::CMD_CLOSE_ALL
      : pins == 3'h5 ? sbr_pkg::CMD_READ
      : pins == 3'h4 ? sbr_pkg::CMD_WRITE
      : sbr_pkg::CMD_NOP;
   wire is_open = cmd == sbr_pkg::CMD_OPEN_ROW;
   wire is_read = cmd == sbr_pkg::CMD_READ;
   wire is_write = cmd == sbr_pkg::CMD_WRITE;
   wire is_close_all = cmd == sbr_pkg::CMD_CLOSE_ALL;
   wire close_burst = is_close_all || (cmd == sbr_pkg::CMD_CLOSE_ONE && bank == bank_reg);
   wire lat3 = read_latency_i == sbr_pkg::READ_LATENCY_3;

   // burst length decode; reserved codes behave as full page
   wire bl_full = !(burst_len_code_i inside {sbr_pkg::BL_CODE_1, sbr_pkg::BL_CODE_2,
      sbr_pkg::BL_CODE_4, sbr_pkg::BL_CODE_8});
   wire [sbr_pkg::LEFT_W-1:0] bl_words =
      burst_len_code_i == sbr_pkg::BL_CODE_1 ? sbr_pkg::BL_WORDS_1
      : burst_len_code_i == sbr_pkg::BL_CODE_2 ? sbr_pkg::BL_WORDS_2
      : burst_len_code_i == sbr_pkg::BL_CODE_4 ? sbr_pkg::BL_WORDS_4
      : burst_len_code_i == sbr_pkg::BL_CODE_8 ? sbr_pkg::BL_WORDS_8
      : sbr_pkg::BL_WORDS_PAGE;
   wire [sbr_pkg::COL_W-1:0] bl_wrap = sbr_pkg::COL_W'(bl_words - 1'b1);

   function automatic logic [sbr_pkg::COL_W-1:0] col_adv(
      input logic [sbr_pkg::COL_W-1:0] c, input logic [sbr_pkg::COL_W-1:0] w);
      col_adv = (c & ~w) | ((c + 1'b1) & w);
   endfunction

   // read fetch and write capture
   wire rd_fetch = state_reg == sbr_pkg::BURST_READ && !is_write;
   wire wr_cont = state_reg == sbr_pkg::BURST_WRITE && !is_read && !is_write
      && !close_burst;
   wire wr_push = is_write || wr_cont;
   wire cur_last = !full_reg && left_reg == 10'h001;
   wire read_end = rd_fetch && cur_last && !is_read && !close_burst;
   wire auto_fire = (read_end && auto_reg)
      || (state_reg == sbr_pkg::BURST_RECOVER && rec_reg == 4'h0);

   assign push_entry.idx = is_write ? {bank, cmd_col[sbr_pkg::STORE_COL_W-1:0]}
      : {bank_reg, col_reg[sbr_pkg::STORE_COL_W-1:0]};
   assign push_entry.lane_en = ~dqm_i;
   assign push_entry.data = dq_i;

   always_comb begin
      state_next = state_reg;
      bank_next = bank_reg;
      col_next = col_reg;
      wrap_next = wrap_reg;
      left_next = left_reg;
      full_next = full_reg;
      auto_next = auto_reg;
      rec_next = rec_reg;
      if (rd_fetch || wr_cont) begin
         col_next = col_adv(col_reg, wrap_reg);
         if (!full_reg) left_next = left_reg - 1'b1;
      end
      if (state_reg == sbr_pkg::BURST_RECOVER) rec_next = rec_reg - 1'b1;
      unique case (state_reg)
         sbr_pkg::BURST_IDLE: ;
         sbr_pkg::BURST_READ: begin
            if (close_burst || read_end) state_next = sbr_pkg::BURST_IDLE;
         end
         sbr_pkg::BURST_WRITE: begin
            if (close_burst) begin
               state_next = sbr_pkg::BURST_IDLE;
            end else if (wr_cont && cur_last) begin
               state_next = auto_reg ? sbr_pkg::BURST_RECOVER : sbr_pkg::BURST_IDLE;
               rec_next = sbr_pkg::WR_RECOVERY_CYCLES - 1'b1;
            end
         end
         sbr_pkg::BURST_RECOVER: begin
            if (rec_reg == 4'h0) state_next = sbr_pkg::BURST_IDLE;
         end
      endcase
      if (is_read || is_write) begin
         bank_next = bank;
         wrap_next = bl_wrap;
         full_next = bl_full;
         auto_next = auto_bit && !bl_full;
         state_next = is_read ? sbr_pkg::BURST_READ : sbr_pkg::BURST_WRITE;
         col_next = is_read ? cmd_col : col_adv(cmd_col, bl_wrap);
         left_next = is_read ? bl_words : bl_words - 1'b1;
         if (is_write && !bl_full && bl_words == sbr_pkg::BL_WORDS_1) begin
            state_next = auto_bit ? sbr_pkg::BURST_RECOVER : sbr_pkg::BURST_IDLE;
            rec_next = sbr_pkg::WR_RECOVERY_CYCLES - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         state_reg <= sbr_pkg::BURST_IDLE;
         bank_reg <= 2'h0;
         col_reg <= sbr_pkg::COL_RESET;
         wrap_reg <= sbr_pkg::COL_RESET;
         left_reg <= '0;
         full_reg <= 1'b0;
         auto_reg <= 1'b0;
         rec_reg <= 4'h0;
      end else begin
         state_reg <= state_next;
         bank_reg <= bank_next;
         col_reg <= col_next;
         wrap_reg <= wrap_next;
         left_reg <= left_next;
         full_reg <= full_next;
         auto_reg <= auto_next;
         rec_reg <= rec_next;
      end
   end

   // one state bit and one row per bank
   genvar gb;
   generate
      for (gb = 0; gb < sbr_pkg::BANKS; gb++) begin : g_bank
         wire hit = bank == 2'(gb);
         wire closing = is_close_all || (cmd == sbr_pkg::CMD_CLOSE_ONE && hit)
            || (auto_fire && bank_reg == 2'(gb));
         always_ff @(posedge sys_clk_i) begin
            if (!resetn_i) begin
               active_reg[gb] <= sbr_pkg::ACTIVE_RESET[gb];
               row_reg[gb] <= sbr_pkg::ROW_RESET;
            end else if (is_open && hit) begin
               active_reg[gb] <= 1'b1;
               row_reg[gb] <= addr_i;
            end else if (closing) begin
               active_reg[gb] <= 1'b0;
            end
         end
      end
   endgenerate
   assign bank_active_o = active_reg;

   // written words drain into storage only when the read port is free;
   // no read fetch ever follows a push by one cycle, so the fifo holds at most one word and wr_fifo_ready_o stays high
   sbr_fifo #(
      .WIDTH($bits(sbr_pkg::sbr_wr_entry_type)),
      .DEPTH(sbr_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .in_valid_i(wr_push),
      .in_ready_o(wr_fifo_ready_o),
      .in_data_i(push_entry),
      .out_valid_o(drain_valid),
      .out_ready_i(!rd_fetch),
      .out_data_o(drain_entry)
   );

   // lanes merge into one word so the array has a single writer process
   logic [sbr_pkg::DATA_W-1:0] merged_word;
   genvar gl;
   generate
      for (gl = 0; gl < sbr_pkg::LANES; gl++) begin : g_lane
         assign merged_word[gl*8 +: 8] = drain_entry.lane_en[gl] ? drain_entry.data[gl*8 +: 8]
            : mem_reg[drain_entry.idx][gl*8 +: 8];
      end
   endgenerate
   always_ff @(posedge sys_clk_i) begin
      if (drain_valid && !rd_fetch) mem_reg[drain_entry.idx] <= merged_word;
   end

   // read pipeline: latency two enters the last stage directly
   wire [sbr_pkg::DATA_W-1:0] rd_word = mem_reg[{bank_reg, col_reg[sbr_pkg::STORE_COL_W-1:0]}];
   wire pb_valid_next = lat3 ? pa_valid_reg : rd_fetch;
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         pa_valid_reg <= 1'b0;
         pb_valid_reg <= 1'b0;
         pa_data_reg <= sbr_pkg::DATA_RESET;
         pb_data_reg <= sbr_pkg::DATA_RESET;
         dqm_d1_reg <= '1;
         oe_n_reg <= '1;
      end else begin
         pa_valid_reg <= rd_fetch;
         pa_data_reg <= rd_word;
         pb_valid_reg <= pb_valid_next;
         pb_data_reg <= lat3 ? pa_data_reg : rd_word;
         dqm_d1_reg <= dqm_i;
         oe_n_reg <= ~({sbr_pkg::LANES{pb_valid_next}} & ~dqm_d1_reg);
      end
   end
   assign dq_o = pb_data_reg;
   assign dq_oe_n_o = oe_n_reg;

   // checks
   property p_open_row;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      is_open |=> active_reg[$past(bank)] && row_reg[$past(bank)] == $past(addr_i);
   endproperty
   a_open_row: assert property (p_open_row) else $error("open row not captured");

   property p_others_kept;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (is_open && !auto_fire) |=> ((active_reg ^ $past(active_reg)) & ~(4'h1 << $past(bank))) == 4'h0;
   endproperty
   a_others_kept: assert property (p_others_kept) else $error("other bank disturbed");

   property p_close_one;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      cmd == sbr_pkg::CMD_CLOSE_ONE |=> !active_reg[$past(bank)];
   endproperty
   a_close_one: assert property (p_close_one) else $error("bank not closed");

   property p_close_all;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      is_close_all |=> active_reg == 4'h0;
   endproperty
   a_close_all: assert property (p_close_all) else $error("banks left open");

   property p_lat2;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (is_read && !lat3) ##1 !is_write |-> ##1 pb_valid_reg;
   endproperty
   a_lat2: assert property (p_lat2) else $error("latency two word missing");

   property p_lat3;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (is_read && lat3 && $stable(read_latency_i)) ##1 (!is_write && lat3) |-> ##2 pb_valid_reg;
   endproperty
   a_lat3: assert property (p_lat3) else $error("latency three word missing");

   property p_mask;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (pb_valid_reg && $past(dqm_i[0], 2)) |-> dq_oe_n_o[0];
   endproperty
   a_mask: assert property (p_mask) else $error("masked word driven");

   property p_write_capture;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (is_write && wr_fifo_ready_o) |-> wr_push ##1 drain_valid;
   endproperty
   a_write_capture: assert property (p_write_capture) else $error("write word lost");

   property p_read_stops_write;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (state_reg == sbr_pkg::BURST_WRITE && is_read) |-> !wr_push ##1 !wr_cont;
   endproperty
   a_read_stops_write: assert property (p_read_stops_write) else $error("write after read");

   property p_wrap;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (rd_fetch && full_reg && col_reg == 9'h1ff && !is_read) |=> col_reg == 9'h000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("page did not wrap");

   property p_page_no_close;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (is_read && auto_bit && bl_full) ##1 (cmd == sbr_pkg::CMD_NOP) [*3] |-> active_reg[bank_reg];
   endproperty
   a_page_no_close: assert property (p_page_no_close) else $error("page burst closed bank");
endmodule

// *** sbr_ctrl_model.sv ***
// memory controller model: command, mask and write data pins of the far side
`timescale 1ns/1ps
module sbr_ctrl_model (
   input wire logic sys_clk_i,
   output logic cs_n_o,
   output logic ras_n_o,
   output logic cas_n_o,
   output logic we_n_o,
   output logic [1:0] bank_o,
   output logic [11:0] addr_o,
   output logic [1:0] dqm_o,
   output logic [15:0] dq_o
);
   initial begin
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
      bank_o = 2'h0;
      addr_o = 12'h000;
      dqm_o = 2'h0;
      dq_o = 16'h0000;
   end

   // one bus cycle; spacing between commands is left to the caller's sequence
   task automatic drive(input logic [2:0] cmd, input logic [1:0] bank, input logic [11:0] addr,
         input logic [1:0] dqm, input logic [15:0] dq);
      sbr_pkg::sbr_cmd_type kind;
      logic [2:0] pins;
      logic [11:0] a;
      kind = sbr_pkg::sbr_cmd_type'(cmd);
      a = addr;
      case (kind)
         sbr_pkg::CMD_OPEN_ROW: pins = 3'h3;
         sbr_pkg::CMD_CLOSE_ONE, sbr_pkg::CMD_CLOSE_ALL: pins = 3'h2;
         sbr_pkg::CMD_READ: pins = 3'h5;
         sbr_pkg::CMD_WRITE: pins = 3'h4;
         default: pins = 3'h7;
      endcase
      if (pins == 3'h2) a[sbr_pkg::AUTO_CLOSE_BIT] = (kind == sbr_pkg::CMD_CLOSE_ALL);
      @(posedge sys_clk_i);
      cs_n_o <= (kind == sbr_pkg::CMD_NOP);
      {ras_n_o, cas_n_o, we_n_o} <= pins;
      bank_o <= bank;
      addr_o <= a;
      dqm_o <= dqm;
      // a released bus must not look like held data, so it changes every cycle
      dq_o <= $isunknown(dq) ? ~dq_o : dq;
   endtask
endmodule

// *** sbr_bank_rw_test.sv ***
// self-checking bench: controller model drives the bank command model
`timescale 1ns/1ps
module sbr_bank_rw_test;
   typedef struct packed {
      logic [2:0] cmd;
      logic [1:0] bank;
      logic [11:0] addr;
      logic [1:0] dqm;
      logic [15:0] dq;
      logic [3:0] act;
      logic [1:0] oe;
      logic [15:0] rd;
   } sbr_row_type;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] lat = 2'h2;
   logic [2:0] bl = 3'h2;
   logic cs_n, ras_n, cas_n, we_n;
   logic [1:0] bank, dqm, oe_n;
   logic [11:0] addr;
   logic [15:0] dq_wr, dq_rd;
   logic [3:0] act;
   logic fifo_rdy;
   int failures = 0;
   int num_checks = 0;
   // cmd 0 nop, 1 open, 2 close one, 3 close all, 4 read, 5 write; x means not checked
   sbr_row_type rows [54] = '{
      '{3'h1,2'h0,12'h005,2'h0,'x,4'h0,2'h3,'x},
      '{3'h1,2'h2,12'h007,2'h0,'x,4'h1,2'h3,'x},
      '{3'h5,2'h0,12'h004,2'h0,16'haaaa,4'h5,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,16'hbbbb,4'h5,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,16'hcccc,4'h5,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,16'hdddd,4'h5,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h3,'x},
      '{3'h4,2'h0,12'h004,2'h0,'x,4'h5,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h1,'x,4'h5,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h0,16'haaaa},
      '{3'h4,2'h0,12'h005,2'h0,'x,4'h5,2'h1,16'hbbbb},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h0,16'hcccc},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h0,16'hbbbb},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h0,16'hcccc},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h0,16'hdddd},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h0,16'haaaa},
      '{3'h4,2'h0,12'h406,2'h0,'x,4'h5,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h0,16'hcccc},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h0,16'hdddd},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h5,2'h0,16'haaaa},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h4,2'h0,16'hbbbb},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h4,2'h3,'x},
      '{3'h3,2'h1,12'h000,2'h0,'x,4'h4,2'h3,'x},
      '{3'h1,2'h0,12'h005,2'h0,'x,4'h0,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h3,'x},
      '{3'h5,2'h0,12'h004,2'h0,16'h1111,4'h1,2'h3,'x},
      '{3'h5,2'h0,12'h006,2'h0,16'h3333,4'h1,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,16'h4444,4'h1,2'h3,'x},
      '{3'h4,2'h0,12'h008,2'h0,16'h5555,4'h1,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h0,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h0,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h0,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h0,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h3,'x},
      '{3'h4,2'h0,12'h004,2'h0,'x,4'h1,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h0,16'h1111},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h0,16'hbbbb},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h0,16'h3333},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h0,16'h4444},
      '{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h3,'x},
      '{3'h4,2'h0,12'h004,2'h0,'x,4'h1,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h3,'x,4'h1,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h3,'x,4'h1,2'h0,16'h1111},
      '{3'h0,2'h0,12'h000,2'h3,'x,4'h1,2'h3,'x},
      '{3'h5,2'h0,12'h008,2'h0,16'h9999,4'h1,2'h3,'x},
      '{3'h0,2'h0,12'h000,2'h0,16'h9a9a,4'h1,2'h3,'x}
   };

   sbr_ctrl_model u_sbr_ctrl_model (.sys_clk_i(clk), .cs_n_o(cs_n), .ras_n_o(ras_n),
      .cas_n_o(cas_n), .we_n_o(we_n), .bank_o(bank), .addr_o(addr), .dqm_o(dqm), .dq_o(dq_wr));

   sbr_bank_rw u_sbr_bank_rw (.sys_clk_i(clk), .resetn_i(resetn), .cs_n_i(cs_n),
      .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .bank_select_low_i(bank[0]),
      .bank_select_high_i(bank[1]), .addr_i(addr), .dqm_i(dqm), .dq_i(dq_wr), .dq_o(dq_rd),
      .dq_oe_n_o(oe_n), .read_latency_i(lat), .burst_len_code_i(bl), .bank_active_o(act),
      .wr_fifo_ready_o(fifo_rdy));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one cycle of pins, then the outputs as they stand in that cycle
   task automatic step(input sbr_row_type r);
      logic [15:0] lm;
      u_sbr_ctrl_model.drive(r.cmd, r.bank, r.addr, r.dqm, r.dq);
      #1;
      lm = {{8{~r.oe[1]}}, {8{~r.oe[0]}}};
      if (!$isunknown(r.act)) cmp(16'(act), 16'(r.act));
      if (!$isunknown(r.oe)) cmp(16'(oe_n), 16'(r.oe));
      if (!$isunknown(r.rd)) cmp(dq_rd & lm, r.rd & lm);
   endtask

   task automatic summarize;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      #1;
      cmp(16'(act), 16'h0000);
      cmp(16'(oe_n), 16'h0003);
      cmp(dq_rd, 16'h0000);
      cmp(16'(fifo_rdy), 16'h0001);
      foreach (rows[i]) step(rows[i]);
      // full page at latency three: wrap past the page end, cut by a close
      @(posedge clk) begin
         lat <= 2'h3;
         bl <= 3'h7;
      end
      step('{3'h5,2'h0,12'h1fe,2'h0,16'he0e0,4'h1,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,16'he1e1,4'h1,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,16'he2e2,4'h1,2'h3,'x});
      step('{3'h2,2'h0,12'h000,2'h3,'x,4'h1,2'h3,'x});
      step('{3'h1,2'h0,12'h000,2'h0,'x,4'h0,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h3,'x});
      step('{3'h4,2'h0,12'h5fe,2'h0,'x,4'h1,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h0,16'he0e0});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h1,2'h0,16'he1e1});
      step('{3'h2,2'h0,12'h000,2'h0,'x,4'h1,2'h0,16'he2e2});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h0,'x,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h0,'x,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h0,2'h3,'x});
      // two-word write with automatic close: bank drops after recovery
      @(posedge clk) begin
         lat <= 2'h2;
         bl <= 3'h1;
      end
      step('{3'h1,2'h1,12'h009,2'h0,'x,4'h0,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h2,2'h3,'x});
      step('{3'h5,2'h1,12'h400,2'h0,16'h7777,4'h2,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,16'h8888,4'h2,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h2,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h0,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h0,2'h3,'x});
      // reset in the middle of a read burst with a bank open
      step('{3'h1,2'h3,12'h001,2'h0,'x,4'h0,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h8,2'h3,'x});
      step('{3'h4,2'h3,12'h000,2'h0,'x,4'h8,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h8,2'h3,'x});
      @(posedge clk) resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      #1;
      cmp(16'(act), 16'h0000);
      cmp(16'(oe_n), 16'h0003);
      cmp(dq_rd, 16'h0000);
      cmp(16'(fifo_rdy), 16'h0001);
      step('{3'h1,2'h3,12'h002,2'h0,'x,4'h0,2'h3,'x});
      step('{3'h0,2'h0,12'h000,2'h0,'x,4'h8,2'h3,'x});
      summarize();
   end

   // the whole sequence needs about 90 cycles
   initial begin
      repeat (1000) @(posedge clk);
      failures++;
      summarize();
   end
endmodule
